// ---- rtl/ccd_line_readout_sequencer.sv ----
// Overview of operation
// - Each line begins with 10 dummy shifts carrying no charge.
// - Dummy positions are never used for the dark reference level.
// - Rows move to horizontal register by sequencing both vertical phases first.
// - Row enters on vertical_phase_two fall; horizontal_phase_one held high then.
// - Horizontal phases toggle as complements, one cycle per pixel.
// - Each last_horizontal_phase fall dumps one packet onto the floating diffusion.
// - Pulse reset_gate after sampling, before the next packet.
// - Both vertical phases stay low during integration.
// - Lines carry 20 dark pixels; quadrants start with 20 dark lines.
`timescale 1ns/1ps
`include "ccd_seq_params.svh"
module ccd_line_readout_sequencer (
   // Clock, reset and enable
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   // Frame control
   input  wire logic        frame_start,
   input  wire logic        integrate_done,
   output logic             busy,
   // Sensor clocks, shared by all four quadrants
   output logic             vertical_phase_one,
   output logic             vertical_phase_two,
   output logic             horizontal_phase_one,
   output logic             horizontal_phase_two,
   output logic             last_horizontal_phase,
   output logic             reset_gate,
   // Digitised video from the four front-end converters
   input  wire logic [55:0] video_sample,
   // Pixel stream out
   output logic             pixel_valid,
   input  wire logic        pixel_ready,
   output logic [16:0]      pixel_data,
   // Dark reference accumulators per quadrant
   output logic [95:0]      dark_sum
);
   // ************************************************************
   // Sequencer state
   // ************************************************************
   ccd_seq_pkg::seq_state_type state;
   ccd_seq_pkg::seq_state_type next_state;
   logic [11:0] pix_cnt;
   logic [11:0] next_pix_cnt;
   logic [11:0] row_cnt;
   logic [11:0] next_row_cnt;
   logic [7:0]  wait_cnt;
   logic [7:0]  next_wait_cnt;
   logic [1:0]  quad;
   logic [1:0]  next_quad;
   logic        v1;
   logic        v2;
   logic        h1;
   logic        h2;
   logic        hl;
   logic        rg;
   logic        next_v1;
   logic        next_v2;
   logic        next_h1;
   logic        next_h2;
   logic        next_hl;
   logic        next_rg;
   logic        next_busy;

   stream_if #(.WIDTH(17)) fill ();
   stream_if #(.WIDTH(17)) drain ();

   // Dummy positions come first and are not pixels at all.
   function automatic logic is_dummy(input logic [11:0] p);
      return p < `DUMMY_SHIFTS;
   endfunction

   // Dark means a shielded column or one of the first shielded rows, never a dummy.
   function automatic logic is_dark(input logic [11:0] p, input logic [11:0] r);
      return !is_dummy(p) && (p < (`DUMMY_SHIFTS + `DARK_PIXELS) || r < `DARK_LINES);
   endfunction

   logic [11:0] wait_len;
   assign wait_len = 12'(`VERT_HOLD_CYCLES);

   always_comb begin
      next_state    = state;
      next_pix_cnt  = pix_cnt;
      next_row_cnt  = row_cnt;
      next_wait_cnt = wait_cnt;
      next_quad     = quad;
      next_v1       = v1;
      next_v2       = v2;
      next_h1       = h1;
      next_hl       = hl;
      next_rg       = rg;
      next_busy     = busy;
      case (state)
         ccd_seq_pkg::st_idle: begin
            next_v1 = 1'b0;
            next_v2 = 1'b0;
            if (frame_start) begin
               next_state = ccd_seq_pkg::st_integrate;
               next_busy  = 1'b1;
            end
         end
         ccd_seq_pkg::st_integrate: begin
            next_v1 = 1'b0;
            next_v2 = 1'b0;
            if (integrate_done) begin
               next_state    = ccd_seq_pkg::st_v1_high;
               next_row_cnt  = '0;
               next_wait_cnt = '0;
               next_v1       = 1'b1;
            end
         end
         ccd_seq_pkg::st_v1_high: begin
            next_h1       = 1'b1;
            next_wait_cnt = 8'(wait_cnt + 1'b1);
            if (12'(wait_cnt) + 12'h001 >= wait_len) begin
               next_state    = ccd_seq_pkg::st_v2_high;
               next_wait_cnt = '0;
               next_v1       = 1'b0;
               next_v2       = 1'b1;
            end
         end
         ccd_seq_pkg::st_v2_high: begin
            next_wait_cnt = 8'(wait_cnt + 1'b1);
            if (12'(wait_cnt) + 12'h001 >= wait_len) begin
               next_state = ccd_seq_pkg::st_v2_fall;
               next_v2    = 1'b0;
            end
         end
         ccd_seq_pkg::st_v2_fall: begin
            next_state   = ccd_seq_pkg::st_pix_shift;
            next_pix_cnt = '0;
         end
         ccd_seq_pkg::st_pix_shift: begin
            // Shift only when the buffer has room for one word; this pixel will make four, one per quadrant.
            if (fill.ready) begin
               next_h1    = 1'b0;
               next_hl    = 1'b1;
               next_state = ccd_seq_pkg::st_pix_dump;
            end
         end
         ccd_seq_pkg::st_pix_dump: begin
            next_h1    = 1'b1;
            next_hl    = 1'b0;
            next_quad  = '0;
            next_state = ccd_seq_pkg::st_pix_reset;
         end
         ccd_seq_pkg::st_pix_reset: begin
            if (fill.ready) begin
               next_quad = 2'(quad + 1'b1);
               if (quad == 2'h3) begin
                  next_rg = 1'b1;
               end
            end
            if (rg) begin
               next_rg      = 1'b0;
               next_pix_cnt = 12'(pix_cnt + 1'b1);
               if (pix_cnt + 12'h001 < `PIXELS_PER_LINE) begin
                  next_state = ccd_seq_pkg::st_pix_shift;
               end else if (row_cnt + 12'h001 < `LINES_PER_QUAD) begin
                  next_row_cnt  = 12'(row_cnt + 1'b1);
                  next_wait_cnt = '0;
                  next_v1       = 1'b1;
                  next_state    = ccd_seq_pkg::st_v1_high;
               end else begin
                  next_busy  = 1'b0;
                  next_state = ccd_seq_pkg::st_idle;
               end
            end
         end
         default: next_state = ccd_seq_pkg::st_idle;
      endcase
      // The second phase has its own flop so that both phase pins leave straight from registers.
      next_h2 = !next_h1;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state    <= ccd_seq_pkg::st_idle;
         pix_cnt  <= 12'h000;
         row_cnt  <= 12'h000;
         wait_cnt <= 8'h00;
         quad     <= 2'h0;
         v1       <= 1'b0;
         v2       <= 1'b0;
         h1       <= 1'b1;
         h2       <= 1'b0;
         hl       <= 1'b0;
         rg       <= 1'b0;
         busy     <= 1'b0;
      end else if (clk_en) begin
         state    <= next_state;
         pix_cnt  <= next_pix_cnt;
         row_cnt  <= next_row_cnt;
         wait_cnt <= next_wait_cnt;
         quad     <= next_quad;
         v1       <= next_v1;
         v2       <= next_v2;
         h1       <= next_h1;
         h2       <= next_h2;
         hl       <= next_hl;
         rg       <= next_rg;
         busy     <= next_busy;
      end
   end

   assign vertical_phase_one    = v1;
   assign vertical_phase_two    = v2;
   assign horizontal_phase_one  = h1;
   assign horizontal_phase_two  = h2;
   assign last_horizontal_phase = hl;
   assign reset_gate            = rg;

   // ************************************************************
   // Sampling, dark reference and pixel buffer
   // ************************************************************
   // Samples are taken one quadrant per cycle while the diffusion still holds the packet.
   logic [13:0] cur_sample;
   logic        take;
   assign cur_sample = video_sample[quad*14 +: 14];
   assign take = (state == ccd_seq_pkg::st_pix_reset) && !rg && fill.ready;

   assign fill.valid = take && !is_dummy(pix_cnt);
   assign fill.data  = {quad, is_dark(pix_cnt, row_cnt), cur_sample};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_dark
         logic [23:0] acc;
         logic [23:0] next_acc;
         always_comb begin
            next_acc = acc;
            if (state == ccd_seq_pkg::st_idle && frame_start) begin
               next_acc = '0;
            end else if (take && quad == 2'(g) && is_dark(pix_cnt, row_cnt)) begin
               next_acc = 24'(acc + 24'(cur_sample));
            end
         end
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
               acc <= 24'h000000;
            end else if (clk_en) begin
               acc <= next_acc;
            end
         end
         assign dark_sum[g*24 +: 24] = acc;
      end
   endgenerate

   pixel_fifo #(.WIDTH(17), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .fill    (fill),
      .drain   (drain)
   );

   logic        out_valid;
   logic [16:0] out_data;
   logic        next_out_valid;
   logic [16:0] next_out_data;
   // A single output stage keeps the stream outputs registered.
   assign drain.ready = !out_valid || pixel_ready;
   always_comb begin
      next_out_valid = out_valid;
      next_out_data  = out_data;
      if (drain.ready) begin
         next_out_valid = drain.valid;
         next_out_data  = drain.data;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_valid <= 1'b0;
         out_data  <= 17'h00000;
      end else if (clk_en) begin
         out_valid <= next_out_valid;
         out_data  <= next_out_data;
      end
   end
   assign pixel_valid = out_valid;
   assign pixel_data  = out_data;
endmodule

// ---- rtl/ccd_seq_params.svh ----
`ifndef CCD_SEQ_PARAMS_SVH
`define CCD_SEQ_PARAMS_SVH

`define DUMMY_SHIFTS       12'h00A
`define DARK_PIXELS        12'h014
`define DARK_LINES         12'h014
`define PIXELS_PER_LINE    12'h60A
`define LINES_PER_QUAD     12'h600
`define VERT_HOLD_NS       32'h000003E8
`define CLK_PERIOD_NS      32'h00000032
`define VERT_HOLD_CYCLES   ((`VERT_HOLD_NS + `CLK_PERIOD_NS - 32'h1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH         32'h00000008
`define SAMPLE_WIDTH       32'h0000000E

`endif

// ---- rtl/ccd_seq_pkg.sv ----
package ccd_seq_pkg;
   typedef enum logic [2:0] {
      st_idle      = 3'b000,
      st_integrate = 3'b001,
      st_v1_high   = 3'b010,
      st_v2_high   = 3'b011,
      st_v2_fall   = 3'b100,
      st_pix_shift = 3'b101,
      st_pix_dump  = 3'b110,
      st_pix_reset = 3'b111
   } seq_state_type;

   typedef struct packed {
      logic [1:0]  quadrant;
      logic        dark;
      logic [13:0] sample;
   } pixel_word_type;
endpackage

// ---- rtl/pixel_fifo.sv ----
`timescale 1ns/1ps
module pixel_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Fill side and drain side
   stream_if.sink   fill,
   stream_if.source drain
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign fill.ready  = (count != DEPTH[AW:0]);
   assign drain.valid = (count != '0);
   assign drain.data  = mem[rd_ptr];

   always_comb begin
      push        = fill.valid && fill.ready;
      pop         = drain.valid && drain.ready;
      next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      next_count  = count;
      if (push && !pop) begin
         next_count = (AW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (AW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (clk_en) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && push) begin
         mem[wr_ptr] <= fill.data;
      end
   end
endmodule

// ---- rtl/stream_if.sv ----
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 17);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface

// ---- tb/ccd_line_readout_sequencer_test.sv ----
`timescale 1ns/1ps
// ****************
// Readout bench
// ****************
module ccd_line_readout_sequencer_test;
   logic        clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, frame_start = 1'b0;
   logic        integrate_done = 1'b0, pixel_ready = 1'b0, stall = 1'b0, new_frame = 1'b0;
   logic        busy, vertical_phase_one, vertical_phase_two, horizontal_phase_one;
   logic        horizontal_phase_two, last_horizontal_phase, reset_gate, pixel_valid;
   logic [13:0] seed = 14'h0;
   logic [23:0] s;
   logic [16:0] pixel_data;
   logic [16:0] rx[$];
   logic [95:0] dark_sum;
   logic [55:0] video_sample;
   int          n_errors = 0, compares = 0, hl_rises = 0, h0, k;
   ccd_line_readout_sequencer uut (.clk, .sys_rst, .clk_en, .frame_start, .integrate_done,
      .busy, .vertical_phase_one, .vertical_phase_two, .horizontal_phase_one,
      .horizontal_phase_two, .last_horizontal_phase, .reset_gate, .video_sample,
      .pixel_valid, .pixel_ready, .pixel_data, .dark_sum);
   ccd_sensor_model sensor (.new_frame, .vertical_phase_two, .horizontal_phase_one,
      .last_horizontal_phase, .reset_gate, .seed, .video_sample);
   initial forever #25 clk = ~clk;
   always @(negedge clk) pixel_ready <= !stall && ($urandom % 4 != 0);
   always @(posedge clk) if (pixel_valid && pixel_ready) rx.push_back(pixel_data);
   always @(posedge last_horizontal_phase) hl_rises++;
   function automatic logic [13:0] samp(int r, int p, int q);
      return 14'(seed + q * 1024 + r * 64 + p);
   endfunction
   function automatic logic [16:0] word(int r, int p, int q);
      return {2'(q), 1'(p < 30 || r < 20), samp(r, p, q)};
   endfunction
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic fail_out();
      n_errors++;
      print_verdict();
   endtask
   task automatic chk_word(string what, logic [16:0] exp, logic [16:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_val(string what, logic [23:0] exp, logic [23:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic get_pixels(int r, int p0, int n);
      for (int p = p0; p < p0 + n; p++)
         for (int q = 0; q < 4; q++) begin
            for (k = 0; k < 2000 && rx.size() == 0; k++) @(posedge clk);
            if (rx.size() == 0) fail_out();
            chk_word("pixel", word(r, p, q), rx.pop_front());
         end
   endtask
   task automatic chk_reset();
      chk_val("pins", 24'h10, 24'({busy, vertical_phase_one, vertical_phase_two,
         horizontal_phase_one, horizontal_phase_two, last_horizontal_phase, reset_gate,
         pixel_valid}));
      chk_val("sums", 24'h0, 24'(|dark_sum));
   endtask
   task automatic start_frame();
      @(negedge clk);
      frame_start = 1'b1;
      new_frame = 1'b1;
      @(negedge clk);
      frame_start = 1'b0;
      new_frame = 1'b0;
      repeat (3 + $urandom % 8) begin
         @(negedge clk);
         chk_val("integrate", 24'h4, 24'({busy, vertical_phase_one, vertical_phase_two}));
      end
      clk_en = 1'b0;
      integrate_done = 1'b1;
      repeat (2) begin
         @(negedge clk);
         chk_val("frozen", 24'h4, 24'({busy, vertical_phase_one, vertical_phase_two}));
      end
      clk_en = 1'b1;
      @(negedge clk);
      integrate_done = 1'b0;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      $display("watchdog expired");
      fail_out();
   end
   initial begin
      void'($urandom(32'h339A));
      seed = 14'($urandom);
      repeat (3) @(negedge clk);
      chk_reset();
      sys_rst = 1'b0;
      $display("test reset done");
      start_frame();
      get_pixels(0, 10, 740);
      @(posedge clk);
      stall = 1'b1;
      repeat (40) @(negedge clk);
      h0 = hl_rises;
      frame_start = 1'b1;
      repeat (200) @(negedge clk);
      frame_start = 1'b0;
      chk_val("shifts while full", 24'h0, 24'(hl_rises - h0));
      @(posedge clk);
      stall = 1'b0;
      $display("test stall done");
      get_pixels(0, 750, 796);
      @(negedge clk);
      for (int q = 0; q < 4; q++) begin
         s = 24'h0;
         for (int p = 10; p < 1546; p++) s += samp(0, p, q);
         chk_val("dark sum", s, dark_sum[q*24 +: 24]);
      end
      get_pixels(1, 10, 10);
      $display("test lines done");
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      chk_reset();
      sys_rst = 1'b0;
      rx.delete();
      start_frame();
      get_pixels(0, 10, 4);
      $display("test restart done");
      print_verdict();
   end
endmodule

// ---- tb/ccd_sensor_model.sv ----
`timescale 1ns/1ps
// ****************
// Sensor and converters
// ****************
module ccd_sensor_model (
   // Frame marker and sensor clocks
   input wire logic        new_frame,
   input wire logic        vertical_phase_two,
   input wire logic        horizontal_phase_one,
   input wire logic        last_horizontal_phase,
   input wire logic        reset_gate,
   input wire logic [13:0] seed,
   // Converted samples
   output logic     [55:0] video_sample
);
   int row = -1;
   int pos = 0;
   initial video_sample = 56'h0;
   always @(posedge new_frame) row = -1;
   always @(negedge vertical_phase_two) if (horizontal_phase_one) begin
      row = row + 1;
      pos = 0;
   end
   // Dummy cells hold no charge, so they convert as zero.
   always @(negedge last_horizontal_phase) begin
      // Each quadrant's packet stays in its own register and never spills back into the rows.
      for (int q = 0; q < 4; q++)
         video_sample[q*14 +: 14] <= (pos < 10) ? 14'h0 : 14'(seed + q * 1024 + row * 64 + pos);
      pos = pos + 1;
   end
   // Reset inverts the held level on the diffusion; the old level must not linger for a late sampler.
   always @(posedge reset_gate) video_sample <= ~video_sample;
endmodule

// ---- tb/ccd_seq_checker_sva.sv ----
`timescale 1ns/1ps
// ****************
// Sensor pin timing and stream hold
// ****************
module ccd_seq_checker (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        integrate_done,
   input wire logic        busy,
   input wire logic        vertical_phase_one,
   input wire logic        vertical_phase_two,
   input wire logic        horizontal_phase_one,
   input wire logic        horizontal_phase_two,
   input wire logic        last_horizontal_phase,
   input wire logic        reset_gate,
   input wire logic        pixel_valid,
   input wire logic        pixel_ready,
   input wire logic [16:0] pixel_data
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   h_compl_a: assert property (horizontal_phase_two == !horizontal_phase_one)
      else $error("h phases equal");
   v1_start_a: assert property ($rose(vertical_phase_one) |->
      ($past(integrate_done) || $past(reset_gate)) && !vertical_phase_two)
      else $error("v1 rose early");
   v1_hold_a: assert property ($rose(vertical_phase_one) |->
      ##20 (!vertical_phase_one && vertical_phase_two)) else $error("v1 hold wrong");
   v2_hold_a: assert property ($rose(vertical_phase_two) |->
      ##20 $fell(vertical_phase_two)) else $error("v2 hold wrong");
   row_entry_a: assert property ($fell(vertical_phase_two) |->
      horizontal_phase_one && $past(horizontal_phase_one)) else $error("h1 low at v2 fall");
   shift_quiet_a: assert property (last_horizontal_phase || reset_gate |->
      !vertical_phase_one && !vertical_phase_two) else $error("vertical during shift");
   dump_pulse_a: assert property ($rose(last_horizontal_phase) |-> !horizontal_phase_one
      ##1 (horizontal_phase_one && !last_horizontal_phase)) else $error("dump pulse wrong");
   sample_gap_a: assert property ($fell(last_horizontal_phase) |->
      !reset_gate [*4] ##[1:1000] reset_gate) else $error("reset gate timing");
   stream_hold_a: assert property (pixel_valid && !pixel_ready |=>
      pixel_valid && $stable(pixel_data)) else $error("word dropped");
   cover property ($fell(vertical_phase_two));
   cover property (pixel_valid && !pixel_ready);
   cover property ($rose(reset_gate));
endmodule
bind ccd_line_readout_sequencer ccd_seq_checker u_chk (.clk, .sys_rst, .integrate_done, .busy,
   .vertical_phase_one, .vertical_phase_two, .horizontal_phase_one, .horizontal_phase_two,
   .last_horizontal_phase, .reset_gate, .pixel_valid, .pixel_ready, .pixel_data);
